// *** src/kbdc_pkg.sv ***
package kbdc_pkg;

	// Host command codes written to the command port
	localparam logic [7:0] CMD_READ_CFG   = 8'h20;
	localparam logic [7:0] CMD_WRITE_CFG  = 8'h60;
	localparam logic [7:0] CMD_RAM_FIRST  = 8'h61;
	localparam logic [7:0] CMD_RAM_LAST   = 8'h7F;
	localparam logic [7:0] CMD_ROM_READ   = 8'hA0;
	localparam logic [7:0] CMD_VERSION    = 8'hA1;
	localparam logic [7:0] CMD_PWD_TEST   = 8'hA4;

	// Responses and fixed values
	localparam logic [7:0] RESP_PWD_SET   = 8'hFA;
	localparam logic [7:0] ROM_END_BYTE   = 8'h00;
	localparam logic [7:0] REGB_CLEAR     = 8'h00;
	localparam logic [7:0] REGB_RESET     = 8'h00;
	// Arbitrary neutral version code
	localparam logic [7:0] VERSION_CODE   = 8'h5A;

	// Configuration byte layout
	localparam int CFG_KBD_IRQ_EN  = 0;
	localparam int CFG_AUX_IRQ_EN  = 1;
	localparam int CFG_SYS_FLAG    = 2;
	localparam int CFG_LOCK_OVR    = 3;
	localparam int CFG_KBD_DIS     = 4;
	localparam int CFG_AUX_DIS     = 5;
	localparam int CFG_XLATE_EN    = 6;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h7F;
	localparam logic [7:0] CFG_RESET      = 8'h00;

	// Internal RAM written by the 61-7F range
	localparam int RAM_DEPTH = 31;
	localparam int RAM_IDX_W = 5;
	localparam logic [RAM_IDX_W-1:0] RAM_IDX_RESET = 5'h00;
	localparam logic [7:0] RAM_RESET = 8'h00;

	// Internal ROM
	localparam int ROM_IDX_W = 3;
	localparam logic [ROM_IDX_W-1:0] ROM_IDX_RESET = 3'h0;
	localparam logic [ROM_IDX_W-1:0] ROM_IDX_STEP  = 3'h1;

	// Scan-code translation
	localparam logic [7:0] XLATE_BREAK_PREFIX = 8'hF0;
	localparam logic [7:0] XLATE_BREAK_BIT    = 8'h80;

	typedef enum logic [1:0] {
		CMD_IDLE     = 2'b00,
		CMD_WAIT_CFG = 2'b01,
		CMD_WAIT_RAM = 2'b10,
		CMD_ROM_SEQ  = 2'b11
	} kbdc_cmd_state_t;

	typedef struct packed {
		logic       wr;
		logic       isCmd;
		logic [7:0] data;
	} kbdc_host_wr_t;

	typedef struct packed {
		logic       full;
		logic       aux;
		logic [7:0] data;
	} kbdc_ob_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} kbdc_byte_t;

endpackage

// *** src/kbdc_rom.sv ***
`timescale 1ns/1ps
module kbdc_rom
	import kbdc_pkg::*;
(
	input  wire logic [ROM_IDX_W-1:0] romIdx,
	output logic      [7:0]           romData
);

	function automatic logic [7:0] romByte(input logic [ROM_IDX_W-1:0] idx);
		case (idx)
			3'h0:    romByte = VERSION_CODE;
			3'h1:    romByte = 8'h01;
			3'h2:    romByte = 8'h02;
			3'h3:    romByte = 8'h03;
			// Past the last entry the sequence terminator is returned
			default: romByte = ROM_END_BYTE;
		endcase
	endfunction

	assign romData = romByte(romIdx);

endmodule // kbdc_rom

// *** src/kbdc_xlate.sv ***
`timescale 1ns/1ps
module kbdc_xlate
	import kbdc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire kbdc_byte_t inByte,
	output logic            inReady,
	output kbdc_byte_t      outByte,
	input  wire logic       outReady
);

	typedef struct packed {
		logic       breakPending;
		kbdc_byte_t hold;
	} kbdc_xlate_state_t;

	kbdc_xlate_state_t s;
	kbdc_xlate_state_t next_s;

	// Small code map; codes outside it pass unchanged
	function automatic logic [7:0] mapCode(input logic [7:0] code);
		case (code)
			8'h76:   mapCode = 8'h01;
			8'h16:   mapCode = 8'h02;
			8'h1E:   mapCode = 8'h03;
			8'h26:   mapCode = 8'h04;
			8'h5A:   mapCode = 8'h1C;
			8'h29:   mapCode = 8'h39;
			default: mapCode = code;
		endcase
	endfunction

	// One-entry hold register so the break prefix and its code collapse into a single byte
	assign inReady = !s.hold.valid || outReady;
	assign outByte = s.hold;

	always_comb begin
		next_s = s;
		if (outReady) begin
			next_s.hold.valid = 1'b0;
		end
		if (inByte.valid && inReady) begin
			if (!enable) begin
				next_s.hold         = inByte;
				next_s.breakPending = 1'b0;
			end else if (inByte.data == XLATE_BREAK_PREFIX) begin
				next_s.breakPending = 1'b1;
			end else begin
				next_s.hold.valid   = 1'b1;
				next_s.hold.data    = mapCode(inByte.data) | (s.breakPending ? XLATE_BREAK_BIT : 8'h00);
				next_s.breakPending = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // kbdc_xlate

// *** src/kbdc_cmd_byte.sv ***
`timescale 1ns/1ps
// Operation
// - Command 60 makes the next data-port byte the configuration byte.
// - Bit 0 set: interrupt each time keyboard data enters the output buffer.
// - Plain keyboard mode: bit 1 is reserved, written zero, has no function.
// - Mouse mode with bit 1 set: auxiliary interrupt when mouse data is buffered.
// - Bit 2 is copied to the status system flag.
// - Bit 3 one: keylock switch is ignored and cannot inhibit keyboard.
// - Bit 4 one: keyboard clock held low, no keyboard send or receive.
// - Bit 5 one: mouse clock held low, no mouse send or receive.
// - Bit 6 one: keyboard scan codes translated, two-byte sequences collapsed.
// - Commands 61-7F write the next data byte into the selected RAM location.
// - Command A0 returns ROM bytes in turn, ending with a zero byte.
// - Password test answers FAh when a password is installed.
// - Password test also clears internal register B to zero.
// - Command A1 loads the version code into the output buffer.
// - The password test command is code A4.
// - Command 20 returns the current configuration byte.
module kbdc_cmd_byte
	import kbdc_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire kbdc_host_wr_t        hostWr,
	input  wire logic                 hostObRead,
	output kbdc_ob_t                  outBuf,
	output logic                      irqKbd,
	output logic                      irqAux,
	output logic                      sysFlag,
	output logic                      keyboardInhibit,
	input  wire logic                 auxModeSel,
	input  wire logic                 keylock_switch_input,
	input  wire logic                 passwordInstalled,
	input  wire kbdc_byte_t           kbdRx,
	output logic                      kbdRxReady,
	input  wire kbdc_byte_t           mouseRx,
	output logic                      mouseRxReady,
	output logic                      kbdClkOut,
	output logic                      kbdClkOe_n,
	output logic                      mouseClkOut,
	output logic                      mouseClkOe_n,
	output logic      [7:0]           cfgByte,
	output logic      [7:0]           regB,
	input  wire logic [RAM_IDX_W-1:0] ramRdIdx,
	output logic      [7:0]           ramRdData
);

	typedef struct packed {
		kbdc_cmd_state_t                fsm;
		logic [7:0]                     cfg;
		logic [RAM_IDX_W-1:0]           ramIdx;
		logic [RAM_DEPTH-1:0][7:0]      ram;
		logic [ROM_IDX_W-1:0]           romIdx;
		logic                           respValid;
		logic [7:0]                     respData;
		kbdc_ob_t                       ob;
		logic                           irqKbd;
		logic                           irqAux;
		logic [7:0]                     regB;
	} kbdc_main_state_t;

	kbdc_main_state_t s;
	kbdc_main_state_t next_s;

	logic       kbdActive;
	logic       mouseActive;
	logic       auxIrqUsable;
	logic       obFree;
	logic       cmdSourceBusy;
	logic       takeMouse;
	logic       takeKbd;
	logic [7:0] romData;
	kbdc_byte_t xlIn;
	kbdc_byte_t xlOut;
	logic       xlInReady;

	// Configuration fields; bit 7 is stored as zero and drives nothing
	logic       cfgKbdIrqEn;
	logic       cfgAuxIrqEn;
	logic       cfgSysFlag;
	logic       cfgLockOvr;
	logic       cfgKbdDis;
	logic       cfgAuxDis;
	logic       cfgXlateEn;

	// Host port decode, shared by the command and data paths
	logic       cmdWr;
	logic       dataWr;
	logic       cmdReadCfg;
	logic       cmdWriteCfg;
	logic       cmdRamWrite;
	logic       cmdRomRead;
	logic       cmdVersion;
	logic       cmdPwdTest;

	// Output buffer fill strobes for command answers
	logic       loadResp;
	logic       loadRom;

	// Index 31 has no cell behind it and reads as the reset value
	logic       ramRdInRange;

	function automatic logic isRamWrite(input logic [7:0] code);
		isRamWrite = (code >= CMD_RAM_FIRST) && (code <= CMD_RAM_LAST);
	endfunction

	function automatic logic [RAM_IDX_W-1:0] ramSlot(input logic [7:0] code);
		logic [7:0] diff;
		diff    = code - CMD_RAM_FIRST;
		ramSlot = diff[RAM_IDX_W-1:0];
	endfunction

	assign cfgKbdIrqEn = s.cfg[CFG_KBD_IRQ_EN];
	assign cfgAuxIrqEn = s.cfg[CFG_AUX_IRQ_EN];
	assign cfgSysFlag  = s.cfg[CFG_SYS_FLAG];
	assign cfgLockOvr  = s.cfg[CFG_LOCK_OVR];
	assign cfgKbdDis   = s.cfg[CFG_KBD_DIS];
	assign cfgAuxDis   = s.cfg[CFG_AUX_DIS];
	assign cfgXlateEn  = s.cfg[CFG_XLATE_EN];

	// Locked keyboard is treated as inhibited unless the override bit is set
	assign keyboardInhibit = keylock_switch_input && !cfgLockOvr;
	assign kbdActive       = !cfgKbdDis && !keyboardInhibit;
	assign mouseActive     = auxModeSel && !cfgAuxDis;
	// Bit 1 only means something when the mouse port exists
	assign auxIrqUsable    = auxModeSel && cfgAuxIrqEn;

	// Command responses and ROM streaming outrank device traffic in the buffer
	assign obFree        = !s.ob.full;
	assign cmdSourceBusy = s.respValid || (s.fsm == CMD_ROM_SEQ);
	assign takeMouse     = obFree && !cmdSourceBusy && mouseActive && mouseRx.valid;
	assign takeKbd       = obFree && !cmdSourceBusy && !takeMouse && xlOut.valid;
	// An answer waits one cycle in respData, then takes the empty buffer first
	assign loadResp      = obFree && s.respValid;
	assign loadRom       = obFree && !s.respValid && (s.fsm == CMD_ROM_SEQ);

	// One write is one pulse; a command write also ends any wait for a data byte
	assign cmdWr       = hostWr.wr && hostWr.isCmd;
	assign dataWr      = hostWr.wr && !hostWr.isCmd;
	assign cmdReadCfg  = cmdWr && (hostWr.data == CMD_READ_CFG);
	assign cmdWriteCfg = cmdWr && (hostWr.data == CMD_WRITE_CFG);
	assign cmdRamWrite = cmdWr && isRamWrite(hostWr.data);
	assign cmdRomRead  = cmdWr && (hostWr.data == CMD_ROM_READ);
	assign cmdVersion  = cmdWr && (hostWr.data == CMD_VERSION);
	assign cmdPwdTest  = cmdWr && (hostWr.data == CMD_PWD_TEST);

	// Disabled interfaces stall their sources so nothing is received
	assign mouseRxReady = takeMouse;
	assign xlIn.valid   = kbdRx.valid && kbdActive;
	assign xlIn.data    = kbdRx.data;
	assign kbdRxReady   = xlInReady && kbdActive;

	// Clock pins: driven low while the interface is disabled, released otherwise
	assign kbdClkOut    = 1'b0;
	assign kbdClkOe_n   = !cfgKbdDis;
	assign mouseClkOut  = 1'b0;
	assign mouseClkOe_n = !cfgAuxDis;

	assign outBuf       = s.ob;
	assign irqKbd       = s.irqKbd;
	assign irqAux       = s.irqAux;
	assign sysFlag      = cfgSysFlag;
	assign cfgByte      = s.cfg;
	assign regB         = s.regB;
	assign ramRdInRange = int'(ramRdIdx) < RAM_DEPTH;
	assign ramRdData    = ramRdInRange ? s.ram[ramRdIdx] : RAM_RESET;

	kbdc_rom u_rom (
		.romIdx  (s.romIdx),
		.romData (romData)
	);

	kbdc_xlate u_xlate (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.enable   (cfgXlateEn),
		.inByte   (xlIn),
		.inReady  (xlInReady),
		.outByte  (xlOut),
		.outReady (takeKbd)
	);

	always_comb begin
		next_s        = s;
		// Interrupt outputs are single-cycle pulses
		next_s.irqKbd = 1'b0;
		next_s.irqAux = 1'b0;

		// A host read frees the buffer at the next edge; a refill follows one cycle later
		if (hostObRead) begin
			next_s.ob.full = 1'b0;
		end

		// Output buffer loading, at most one source per cycle
		if (loadResp) begin
			next_s.ob.full   = 1'b1;
			next_s.ob.aux    = 1'b0;
			next_s.ob.data   = s.respData;
			next_s.respValid = 1'b0;
		end else if (loadRom) begin
			next_s.ob.full = 1'b1;
			next_s.ob.aux  = 1'b0;
			next_s.ob.data = romData;
			next_s.romIdx  = s.romIdx + ROM_IDX_STEP;
			// The terminator itself is delivered before the stream stops
			if (romData == ROM_END_BYTE) begin
				next_s.fsm = CMD_IDLE;
			end
		end else if (takeMouse) begin
			next_s.ob.full = 1'b1;
			next_s.ob.aux  = 1'b1;
			next_s.ob.data = mouseRx.data;
			next_s.irqAux  = auxIrqUsable;
		end else if (takeKbd) begin
			next_s.ob.full = 1'b1;
			next_s.ob.aux  = 1'b0;
			next_s.ob.data = xlOut.data;
			next_s.irqKbd  = cfgKbdIrqEn;
		end

		// Command port: a new command abandons any wait and any ROM stream
		if (cmdWr) begin
			next_s.fsm = CMD_IDLE;
		end

		if (cmdReadCfg) begin
			next_s.respValid = 1'b1;
			next_s.respData  = s.cfg & CFG_WRITE_MASK;
		end

		if (cmdWriteCfg) begin
			next_s.fsm = CMD_WAIT_CFG;
		end

		if (cmdRamWrite) begin
			next_s.fsm    = CMD_WAIT_RAM;
			next_s.ramIdx = ramSlot(hostWr.data);
		end

		if (cmdRomRead) begin
			next_s.fsm    = CMD_ROM_SEQ;
			next_s.romIdx = ROM_IDX_RESET;
		end

		if (cmdVersion) begin
			next_s.respValid = 1'b1;
			next_s.respData  = VERSION_CODE;
		end

		// Register B is cleared whether or not a password is present
		if (cmdPwdTest) begin
			next_s.regB = REGB_CLEAR;
			// With no password the command leaves the buffer untouched
			if (passwordInstalled) begin
				next_s.respValid = 1'b1;
				next_s.respData  = RESP_PWD_SET;
			end
		end

		// Data port: only a pending configuration or RAM command gives the byte a home
		if (dataWr) begin
			case (s.fsm)
				CMD_WAIT_CFG: begin
					// Stored masked so the reserved top bit always reads zero
					next_s.cfg = hostWr.data & CFG_WRITE_MASK;
					next_s.fsm = CMD_IDLE;
				end
				CMD_WAIT_RAM: begin
					next_s.ram[s.ramIdx] = hostWr.data;
					next_s.fsm           = CMD_IDLE;
				end
				CMD_IDLE: begin
					next_s.fsm = CMD_IDLE;
				end
				CMD_ROM_SEQ: begin
					next_s.fsm = CMD_ROM_SEQ;
				end
				default: begin
					next_s.fsm = CMD_IDLE;
				end
			endcase
		end
	end

	// Every field gets a defined value so nothing unknown reaches the host after reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s.fsm       <= CMD_IDLE;
			s.cfg       <= CFG_RESET;
			s.ramIdx    <= RAM_IDX_RESET;
			s.ram       <= {RAM_DEPTH{RAM_RESET}};
			s.romIdx    <= ROM_IDX_RESET;
			s.respValid <= 1'b0;
			s.respData  <= '0;
			s.ob        <= '0;
			s.irqKbd    <= 1'b0;
			s.irqAux    <= 1'b0;
			s.regB      <= REGB_RESET;
		end else begin
			s <= next_s;
		end
	end

endmodule // kbdc_cmd_byte

// *** tb/kbdc_cmd_byte_asserts.sv ***
`timescale 1ns/1ps
module kbdc_cmd_byte_asserts
	import kbdc_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          rst_n,
	input wire kbdc_host_wr_t hostWr,
	input wire kbdc_ob_t      outBuf,
	input wire logic          irqKbd,
	input wire logic          irqAux,
	input wire logic          sysFlag,
	input wire logic          keyboardInhibit,
	input wire logic          auxModeSel,
	input wire logic          keylock_switch_input,
	input wire logic          passwordInstalled,
	input wire kbdc_byte_t    mouseRx,
	input wire logic          mouseRxReady,
	input wire logic          kbdRxReady,
	input wire logic          kbdClkOe_n,
	input wire logic          mouseClkOe_n,
	input wire logic [7:0]    cfgByte,
	input wire logic [7:0]    regB
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic cmdWr = hostWr.wr && hostWr.isCmd;
	// A mouse byte taken at the command edge would compete for the buffer
	wire logic obFree = !outBuf.full && !(mouseRx.valid && mouseRxReady);

	property p_cfg_load;
		cmdWr && hostWr.data == CMD_WRITE_CFG ##1 hostWr.wr && !hostWr.isCmd
			|=> cfgByte == ($past(hostWr.data) & CFG_WRITE_MASK);
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("config byte load wrong");
	property p_sys_flag;
		sysFlag == cfgByte[CFG_SYS_FLAG];
	endproperty
	a_sys_flag: assert property (p_sys_flag) else $error("system flag wrong");
	property p_lock;
		keyboardInhibit == (keylock_switch_input && !cfgByte[CFG_LOCK_OVR]);
	endproperty
	a_lock: assert property (p_lock) else $error("keylock inhibit wrong");
	property p_kbd_off;
		kbdClkOe_n != cfgByte[CFG_KBD_DIS] && !(cfgByte[CFG_KBD_DIS] && kbdRxReady);
	endproperty
	a_kbd_off: assert property (p_kbd_off) else $error("keyboard disable wrong");
	property p_aux_off;
		mouseClkOe_n != cfgByte[CFG_AUX_DIS] && !(cfgByte[CFG_AUX_DIS] && mouseRxReady);
	endproperty
	a_aux_off: assert property (p_aux_off) else $error("mouse disable wrong");
	property p_irq_kbd;
		irqKbd |-> outBuf.full && !outBuf.aux && cfgByte[CFG_KBD_IRQ_EN];
	endproperty
	a_irq_kbd: assert property (p_irq_kbd) else $error("keyboard irq wrong");
	property p_irq_aux;
		mouseRx.valid && mouseRxReady && auxModeSel && cfgByte[CFG_AUX_IRQ_EN]
			|=> irqAux && outBuf.full && outBuf.aux && outBuf.data == $past(mouseRx.data);
	endproperty
	a_irq_aux: assert property (p_irq_aux) else $error("mouse irq wrong");
	property p_aux_mode;
		!$past(auxModeSel) |-> !irqAux;
	endproperty
	a_aux_mode: assert property (p_aux_mode) else $error("mouse irq in keyboard mode");
	// The answer is registered once, then enters the buffer: it shows two edges after the command
	property p_read_cfg;
		cmdWr && hostWr.data == CMD_READ_CFG && obFree ##1 !outBuf.full
			|=> outBuf.full && outBuf.data == $past(cfgByte, 2);
	endproperty
	a_read_cfg: assert property (p_read_cfg) else $error("config read wrong");
	property p_version;
		cmdWr && hostWr.data == CMD_VERSION && obFree ##1 !outBuf.full
			|=> outBuf.full && outBuf.data == VERSION_CODE;
	endproperty
	a_version: assert property (p_version) else $error("version read wrong");
	property p_pwd;
		cmdWr && hostWr.data == CMD_PWD_TEST |=> regB == REGB_CLEAR;
	endproperty
	a_pwd: assert property (p_pwd) else $error("password test wrong");
	property p_pwd_resp;
		cmdWr && hostWr.data == CMD_PWD_TEST && passwordInstalled && obFree ##1 !outBuf.full
			|=> outBuf.full && outBuf.data == RESP_PWD_SET;
	endproperty
	a_pwd_resp: assert property (p_pwd_resp) else $error("password answer wrong");

	c_cfg: cover property (cmdWr && hostWr.data == CMD_WRITE_CFG ##1 hostWr.wr);
	c_irqk: cover property (irqKbd);
	c_irqa: cover property (irqAux);
	c_rom_end: cover property (outBuf.full && outBuf.data == ROM_END_BYTE);
endmodule // kbdc_cmd_byte_asserts

// *** tb/kbdc_dev_model.sv ***
`timescale 1ns/1ps
module kbdc_dev_model
	import kbdc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic kbdRxReady,
	input  wire logic mouseRxReady,
	output kbdc_byte_t kbdRx,
	output kbdc_byte_t mouseRx
);
	initial begin
		kbdRx = '0;
		mouseRx = '0;
	end
	// Idle data is the inverted last byte so a late capture cannot look right
	task automatic sendByte(input logic isMouse, input int gap, input logic [7:0] b);
		repeat (gap + 1) @(posedge clk_sys);
		if (isMouse)
			mouseRx <= '{1'b1, b};
		else
			kbdRx <= '{1'b1, b};
		do @(negedge clk_sys);
		while (!(isMouse ? mouseRxReady : kbdRxReady));
		@(posedge clk_sys);
		if (isMouse)
			mouseRx <= '{1'b0, ~b};
		else
			kbdRx <= '{1'b0, ~b};
	endtask
endmodule // kbdc_dev_model

// *** tb/kbd_ctrl_command_byte_tb.sv ***
`timescale 1ns/1ps
module kbd_ctrl_command_byte_tb
	import kbdc_pkg::*;
;
	logic                 clk_sys = 1'b0, rst_n = 1'b0, hostObRead = 1'b0, auxModeSel = 1'b0;
	logic                 keylock_switch_input = 1'b0, passwordInstalled = 1'b0;
	kbdc_host_wr_t        hostWr = '0;
	logic [RAM_IDX_W-1:0] ramRdIdx = '0;
	kbdc_ob_t             outBuf;
	kbdc_byte_t           kbdRx, mouseRx;
	logic                 irqKbd, irqAux, sysFlag, keyboardInhibit, kbdRxReady, mouseRxReady;
	logic                 kbdClkOut, kbdClkOe_n, mouseClkOut, mouseClkOe_n;
	logic [7:0]           cfgByte, regB, ramRdData;
	logic [7:0]           mk [6] = '{8'h76, 8'h16, 8'h1E, 8'h26, 8'h5A, 8'h29};
	logic [7:0]           xl [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h1C, 8'h39};
	logic [7:0]           rom [5] = '{8'h5A, 8'h01, 8'h02, 8'h03, ROM_END_BYTE};
	int                   err_count = 0, n_compared = 0, nIrqK = 0, nIrqA = 0;

	kbdc_cmd_byte dut_u (.clk_sys, .rst_n, .hostWr, .hostObRead, .outBuf, .irqKbd, .irqAux, .sysFlag,
		.keyboardInhibit, .auxModeSel, .keylock_switch_input, .passwordInstalled, .kbdRx, .kbdRxReady,
		.mouseRx, .mouseRxReady, .kbdClkOut, .kbdClkOe_n, .mouseClkOut, .mouseClkOe_n, .cfgByte, .regB,
		.ramRdIdx, .ramRdData);
	kbdc_dev_model dev_u (.clk_sys, .kbdRxReady, .mouseRxReady, .kbdRx, .mouseRx);

	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		nIrqK += (irqKbd === 1'b1);
		nIrqA += (irqAux === 1'b1);
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hostCmd(input logic [7:0] c, input logic wd = 1'b0, input logic [7:0] d = 8'h00);
		@(posedge clk_sys);
		hostWr <= '{1'b1, 1'b1, c};
		if (wd) begin
			@(posedge clk_sys);
			hostWr <= '{1'b1, 1'b0, d};
		end
		@(posedge clk_sys);
		hostWr <= '0;
		@(negedge clk_sys);
	endtask
	task automatic readOb(input logic [7:0] exp, input logic aux = 1'b0);
		for (int i = 0; i < 50 && outBuf.full !== 1'b1; i++) @(negedge clk_sys);
		check(outBuf, {1'b1, aux, exp});
		@(posedge clk_sys);
		hostObRead <= 1'b1;
		@(posedge clk_sys);
		hostObRead <= 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		keylock_switch_input <= 1'b1;
		@(negedge clk_sys);
		check({sysFlag, kbdClkOe_n, cfgByte}, {2'b01, CFG_RESET});
		hostCmd(CMD_WRITE_CFG, 1'b1, 8'hFF);
		check(10'({sysFlag, keyboardInhibit, kbdClkOe_n, mouseClkOe_n, kbdRxReady, mouseRxReady}), 10'h020);
		hostCmd(CMD_READ_CFG);
		readOb(8'h7F);
		hostCmd(CMD_WRITE_CFG, 1'b1, 8'h01);
		check(10'(keyboardInhibit), 10'h001);
		@(posedge clk_sys);
		keylock_switch_input <= 1'b0;
		dev_u.sendByte(1'b0, 0, 8'h1C);
		readOb(8'h1C);
		@(posedge clk_sys);
		auxModeSel <= 1'b1;
		hostCmd(CMD_WRITE_CFG, 1'b1, 8'h03);
		dev_u.sendByte(1'b1, 3, 8'h33);
		readOb(8'h33, 1'b1);
		@(posedge clk_sys);
		auxModeSel <= 1'b0;
		// Keyboard mode has no mouse port: bit 1 stays set and must add no mouse interrupt
		dev_u.sendByte(1'b0, 0, 8'h44);
		readOb(8'h44);
		check(10'(nIrqK), 10'h002);
		check(10'(nIrqA), 10'h001);
		hostCmd(CMD_WRITE_CFG, 1'b1, 8'h40);
		for (int i = 0; i < 6; i++) begin
			dev_u.sendByte(1'b0, i, mk[i]);
			readOb(xl[i]);
		end
		dev_u.sendByte(1'b0, 0, XLATE_BREAK_PREFIX);
		dev_u.sendByte(1'b0, 0, 8'h5A);
		readOb(8'h9C);
		hostCmd(CMD_WRITE_CFG, 1'b1, 8'h00);
		dev_u.sendByte(1'b0, 0, 8'h76);
		readOb(8'h76);
		check(10'(nIrqK), 10'h002);
		for (int i = 0; i < 31; i += 30) begin
			hostCmd(8'(CMD_RAM_FIRST + i), 1'b1, 8'(8'hA5 ^ i));
			@(posedge clk_sys);
			ramRdIdx <= RAM_IDX_W'(i);
			@(negedge clk_sys);
			check(10'(ramRdData), 10'(8'hA5 ^ i));
		end
		hostCmd(CMD_ROM_READ);
		for (int i = 0; i < 5; i++) readOb(rom[i]);
		repeat (3) @(negedge clk_sys);
		check(10'(outBuf.full), 10'h000);
		hostCmd(CMD_VERSION);
		readOb(VERSION_CODE);
		@(posedge clk_sys);
		passwordInstalled <= 1'b1;
		hostCmd(CMD_PWD_TEST);
		readOb(RESP_PWD_SET);
		@(posedge clk_sys);
		passwordInstalled <= 1'b0;
		hostCmd(CMD_PWD_TEST);
		check({outBuf.full, 1'b0, regB}, {2'b00, REGB_CLEAR});
		summarize();
	end
endmodule // kbd_ctrl_command_byte_tb

bind kbdc_cmd_byte kbdc_cmd_byte_asserts chk_u (.clk_sys, .rst_n, .hostWr, .outBuf, .irqKbd, .irqAux,
	.sysFlag, .keyboardInhibit, .auxModeSel, .keylock_switch_input, .passwordInstalled, .mouseRx,
	.mouseRxReady, .kbdRxReady, .kbdClkOe_n, .mouseClkOe_n, .cfgByte, .regB);
